/* File: tqr_pkg.sv */
`default_nettype none
// How it works
// - Half-full enable high lets event FIFO half-full raise the interrupt.
// - Not-empty enable high lets event FIFO not-empty raise the interrupt.
// - Payload size and depth fields change only in configuration mode.
// - Queue reset bit reads set in configuration mode, clears in normal mode once the queue reset is done.
// - Overflow flag set by hardware on overflow, cleared by software.
// - Full flag reads one when every event FIFO entry is occupied.
// - Half-full flag reads one when occupancy reaches half the depth.
// - Not-empty flag reads one when at least one object is stored.
// - Full, half and not-empty flags are read-only, live from occupancy.
// - User address read returns RAM address of the event FIFO tail.
// - Queue depth is the five-bit field value plus one.
// - With global retry enable: 00 none, 01 three, 1x unlimited.
// - Priority 00000 is lowest, 11111 is highest.
// - Queue reset bit resets the queue then clears; software waits.
// - Send request starts sending; clears when the queue is drained.
// - Writing zero to a set send request asks for an abort.
// - Send request updates on completion, abort, or queue reset.
// - Head increment advances the head by one slot then self-clears.
// - Transmit direction bit is read-only and always reads one.
// - Queue enables gate attempts-done, empty and not-full interrupts.
// - Event FIFO enables for overflow on bit 3, full on bit 2.
package tqr_pkg;
  // ----------------------------------------------------------------
  // Register select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_EVF_CTRL   = 2'h0;
  localparam logic [1:0] SEL_EVF_STATUS = 2'h1;
  localparam logic [1:0] SEL_EVF_TAIL   = 2'h2;
  localparam logic [1:0] SEL_QUEUE_CTRL = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_EVF_OVF = 3;
  localparam int B_EVF_FUL = 2;
  localparam int B_EVF_HLF = 1;
  localparam int B_EVF_NE  = 0;
  localparam int B_Q_PL    = 29;
  localparam int B_Q_DEP   = 24;
  localparam int B_Q_ATT   = 21;
  localparam int B_Q_PRI   = 16;
  localparam int B_Q_RST   = 10;
  localparam int B_Q_SEND  = 9;
  localparam int B_Q_STEP  = 8;
  localparam int B_Q_DIR   = 7;
  localparam int B_Q_ATIE  = 4;
  localparam int B_Q_EIE   = 2;
  localparam int B_Q_NIE   = 0;

  // ----------------------------------------------------------------
  // Reset and retry limit values
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_ATTEMPTS = 2'h3;
  localparam logic [2:0] ATT_THREE    = 3'h3;

  // Configuration bits of the queue control register.
  typedef struct packed {
    logic [2:0] payload_size_sel;
    logic [4:0] queue_depth_sel;
    logic [1:0] retry_attempts_sel;
    logic [4:0] tx_priority;
    logic       attempts_done_irq_en;
    logic       queue_empty_irq_en;
    logic       queue_notfull_irq_en;
  } tqr_qcfg_t;

  // Event FIFO interrupt enables.
  typedef struct packed {
    logic evf_overflow_irq_en;
    logic evf_full_irq_en;
    logic evf_half_irq_en;
    logic evf_nonempty_irq_en;
  } tqr_evfen_t;
endpackage
`default_nettype wire

/* File: tqr_payload_map.sv */
`default_nettype none
// ------------------------------------------------------------------
// Payload size decoder
// ------------------------------------------------------------------
module tqr_payload_map (
  input  wire logic [2:0] sel,
  output logic      [6:0] bytes
);
  // Sizes above 24 step unevenly, so a table beats arithmetic.
  always_comb begin
    case (sel)
      3'h0:    bytes = 7'h08;
      3'h1:    bytes = 7'h0C;
      3'h2:    bytes = 7'h10;
      3'h3:    bytes = 7'h14;
      3'h4:    bytes = 7'h18;
      3'h5:    bytes = 7'h20;
      3'h6:    bytes = 7'h30;
      default: bytes = 7'h40;
    endcase
  end
endmodule
`default_nettype wire

/* File: tqr_regs.sv */
`default_nettype none
// ------------------------------------------------------------------
// Event FIFO and transmit queue register bank
// ------------------------------------------------------------------
module tqr_regs #(
  parameter int EVF_DEPTH = 32,
  parameter int CW        = 6
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [1:0]  REG_SEL,
  input  wire logic [31:0] REG_WDATA,
  output logic      [31:0] REG_RDATA,
  input  wire logic        CONFIG_MODE,
  input  wire logic        RETRY_LIMIT_GLOBAL_EN,
  input  wire logic [CW-1:0] EVF_COUNT,
  input  wire logic [31:0] EVF_TAIL_ADDR,
  input  wire logic        EVF_OVERFLOW_EVT,
  input  wire logic        MSG_DONE,
  input  wire logic        MSG_ABORTED,
  input  wire logic        QUEUE_DRAINED,
  input  wire logic        QUEUE_RESET_DONE,
  input  wire logic        ATTEMPTS_DONE,
  input  wire logic        QUEUE_EMPTY,
  input  wire logic        QUEUE_NOTFULL,
  output logic             QUEUE_RESET_PULSE,
  output logic             HEAD_STEP_PULSE,
  output logic             ABORT_REQ_PULSE,
  output logic             SEND_ACTIVE,
  output logic [6:0]       PAYLOAD_BYTES,
  output logic [5:0]       QUEUE_SLOTS,
  output logic [4:0]       TX_PRIORITY,
  output logic [2:0]       RETRY_LIMIT,
  output logic             IRQ_REQ
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tqr_pkg::tqr_qcfg_t  qcfg_q, qcfg_d;
  tqr_pkg::tqr_evfen_t evfen_q, evfen_d;
  logic ovf_q, ovf_d;
  logic qrst_q, qrst_d;
  logic send_q, send_d;
  logic step_q, step_d;
  logic abort_q, abort_d;
  logic [31:0] rdata_q, rdata_d;
  logic ev_full, ev_half, ev_ne;
  logic wr_ec, wr_es, wr_qc;
  logic send_set;

  assign wr_ec = REG_WR && (REG_SEL == tqr_pkg::SEL_EVF_CTRL);
  assign wr_es = REG_WR && (REG_SEL == tqr_pkg::SEL_EVF_STATUS);
  assign wr_qc = REG_WR && (REG_SEL == tqr_pkg::SEL_QUEUE_CTRL);
  // A fresh send request, which outranks every clearing event.
  assign send_set = wr_qc && REG_WDATA[tqr_pkg::B_Q_SEND];

  // Occupancy flags are purely combinational, so they can never lag.
  assign ev_full = (EVF_COUNT >= CW'(EVF_DEPTH));
  assign ev_half = (EVF_COUNT >= CW'(EVF_DEPTH / 2));
  assign ev_ne   = (EVF_COUNT != '0);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Payload size and depth fields are gated by mode; self-clearing bits pulse.
  always_comb begin
    qcfg_d  = qcfg_q;
    evfen_d = evfen_q;
    ovf_d   = ovf_q;
    qrst_d  = qrst_q;
    send_d  = send_q;
    step_d  = 1'b0;
    abort_d = 1'b0;
    if (wr_ec) begin
      evfen_d.evf_overflow_irq_en = REG_WDATA[tqr_pkg::B_EVF_OVF];
      evfen_d.evf_full_irq_en     = REG_WDATA[tqr_pkg::B_EVF_FUL];
      evfen_d.evf_half_irq_en     = REG_WDATA[tqr_pkg::B_EVF_HLF];
      evfen_d.evf_nonempty_irq_en = REG_WDATA[tqr_pkg::B_EVF_NE];
    end
    // Software clears by writing zero; a fresh event wins that cycle.
    if (wr_es && !REG_WDATA[tqr_pkg::B_EVF_OVF]) begin
      ovf_d = 1'b0;
    end
    if (EVF_OVERFLOW_EVT) begin
      ovf_d = 1'b1;
    end
    if (wr_qc) begin
      if (CONFIG_MODE) begin
        qcfg_d.payload_size_sel =
          REG_WDATA[tqr_pkg::B_Q_PL +: 3];
        qcfg_d.queue_depth_sel  =
          REG_WDATA[tqr_pkg::B_Q_DEP +: 5];
      end
      qcfg_d.retry_attempts_sel   = REG_WDATA[tqr_pkg::B_Q_ATT +: 2];
      qcfg_d.tx_priority          = REG_WDATA[tqr_pkg::B_Q_PRI +: 5];
      qcfg_d.attempts_done_irq_en = REG_WDATA[tqr_pkg::B_Q_ATIE];
      qcfg_d.queue_empty_irq_en   = REG_WDATA[tqr_pkg::B_Q_EIE];
      qcfg_d.queue_notfull_irq_en = REG_WDATA[tqr_pkg::B_Q_NIE];
      if (REG_WDATA[tqr_pkg::B_Q_RST]) begin
        qrst_d = 1'b1;
      end
      if (REG_WDATA[tqr_pkg::B_Q_STEP]) begin
        step_d = 1'b1;
      end
      if (REG_WDATA[tqr_pkg::B_Q_SEND]) begin
        send_d = 1'b1;
      end else if (send_q) begin
        abort_d = 1'b1;
      end
    end
    // Completion, abort or a landed queue reset drops the request; a
    // request written in the same cycle still wins, so none is lost.
    if ((QUEUE_DRAINED || MSG_ABORTED) && !send_set) begin
      send_d = 1'b0;
    end
    if (MSG_DONE && QUEUE_DRAINED && !send_set) begin
      send_d = 1'b0;
    end
    if (qrst_q && QUEUE_RESET_DONE && !send_set) begin
      send_d = 1'b0;
    end
    // Held set throughout configuration, released once the reset lands.
    if (CONFIG_MODE) begin
      qrst_d = 1'b1;
    end else if (qrst_q && QUEUE_RESET_DONE) begin
      qrst_d = 1'b0;
    end
  end

  // Read mux; the tail address is only meaningful outside configuration.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (REG_RD) begin
      case (REG_SEL)
        tqr_pkg::SEL_EVF_CTRL: begin
          rdata_d[tqr_pkg::B_EVF_OVF] = evfen_q.evf_overflow_irq_en;
          rdata_d[tqr_pkg::B_EVF_FUL] = evfen_q.evf_full_irq_en;
          rdata_d[tqr_pkg::B_EVF_HLF] = evfen_q.evf_half_irq_en;
          rdata_d[tqr_pkg::B_EVF_NE]  = evfen_q.evf_nonempty_irq_en;
          rdata_d[tqr_pkg::B_Q_RST]   = qrst_q;
        end
        tqr_pkg::SEL_EVF_STATUS: begin
          rdata_d[tqr_pkg::B_EVF_OVF] = ovf_q;
          rdata_d[tqr_pkg::B_EVF_FUL] = ev_full;
          rdata_d[tqr_pkg::B_EVF_HLF] = ev_half;
          rdata_d[tqr_pkg::B_EVF_NE]  = ev_ne;
        end
        tqr_pkg::SEL_EVF_TAIL: begin
          rdata_d = EVF_TAIL_ADDR;
        end
        tqr_pkg::SEL_QUEUE_CTRL: begin
          rdata_d[tqr_pkg::B_Q_PL +: 3]  = qcfg_q.payload_size_sel;
          rdata_d[tqr_pkg::B_Q_DEP +: 5] = qcfg_q.queue_depth_sel;
          rdata_d[tqr_pkg::B_Q_ATT +: 2] = qcfg_q.retry_attempts_sel;
          rdata_d[tqr_pkg::B_Q_PRI +: 5] = qcfg_q.tx_priority;
          rdata_d[tqr_pkg::B_Q_RST]      = qrst_q;
          rdata_d[tqr_pkg::B_Q_SEND]     = send_q;
          rdata_d[tqr_pkg::B_Q_DIR]      = 1'b1;
          rdata_d[tqr_pkg::B_Q_ATIE]     = qcfg_q.attempts_done_irq_en;
          rdata_d[tqr_pkg::B_Q_EIE]      = qcfg_q.queue_empty_irq_en;
          rdata_d[tqr_pkg::B_Q_NIE]      = qcfg_q.queue_notfull_irq_en;
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset; the queue reset bit comes up set as after power-on.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      qcfg_q  <= '{retry_attempts_sel: tqr_pkg::RST_ATTEMPTS, default: '0};
      evfen_q <= '0;
      ovf_q   <= 1'b0;
      qrst_q  <= 1'b1;
      send_q  <= 1'b0;
      step_q  <= 1'b0;
      abort_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      qcfg_q  <= qcfg_d;
      evfen_q <= evfen_d;
      ovf_q   <= ovf_d;
      qrst_q  <= qrst_d;
      send_q  <= send_d;
      step_q  <= step_d;
      abort_q <= abort_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  tqr_payload_map u_pl (
    .sel   (qcfg_q.payload_size_sel),
    .bytes (PAYLOAD_BYTES)
  );

  // Retry limit: 0 none, 3 three tries, 7 unlimited.
  always_comb begin
    if (!RETRY_LIMIT_GLOBAL_EN) begin
      RETRY_LIMIT = 3'h7;
    end else begin
      case (qcfg_q.retry_attempts_sel)
        2'h0:    RETRY_LIMIT = 3'h0;
        2'h1:    RETRY_LIMIT = tqr_pkg::ATT_THREE;
        default: RETRY_LIMIT = 3'h7;
      endcase
    end
  end

  assign QUEUE_SLOTS       = {1'b0, qcfg_q.queue_depth_sel} + 6'h01;
  assign TX_PRIORITY       = qcfg_q.tx_priority;
  assign QUEUE_RESET_PULSE = qrst_q && !CONFIG_MODE;
  assign HEAD_STEP_PULSE   = step_q;
  assign ABORT_REQ_PULSE   = abort_q;
  assign SEND_ACTIVE       = send_q;
  assign REG_RDATA         = rdata_q;

  // One shared request line, gated per source by its enable.
  assign IRQ_REQ = (ovf_q && evfen_q.evf_overflow_irq_en)
                || (ev_full && evfen_q.evf_full_irq_en)
                || (ev_half && evfen_q.evf_half_irq_en)
                || (ev_ne && evfen_q.evf_nonempty_irq_en)
                || (ATTEMPTS_DONE && qcfg_q.attempts_done_irq_en)
                || (QUEUE_EMPTY && qcfg_q.queue_empty_irq_en)
                || (QUEUE_NOTFULL && qcfg_q.queue_notfull_irq_en);
endmodule
`default_nettype wire

/* File: tqr_regs_props.sv */
`default_nettype none
// --------
// Port checker for the register bank
// --------
module tqr_regs_props #(
  parameter int EVF_DEPTH = 32,
  parameter int CW        = 6
) (
  input wire logic          CORE_CLK,
  input wire logic          RST,
  input wire logic          REG_WR,
  input wire logic          REG_RD,
  input wire logic [1:0]    REG_SEL,
  input wire logic [31:0]   REG_WDATA,
  input wire logic [31:0]   REG_RDATA,
  input wire logic          CONFIG_MODE,
  input wire logic [CW-1:0] EVF_COUNT,
  input wire logic [31:0]   EVF_TAIL_ADDR,
  input wire logic          EVF_OVERFLOW_EVT,
  input wire logic          QUEUE_DRAINED,
  input wire logic          HEAD_STEP_PULSE,
  input wire logic          SEND_ACTIVE,
  input wire logic [5:0]    QUEUE_SLOTS
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks sample on the core clock and rest while reset is high.
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  // Write strobe aimed at the queue control register.
  logic qw;
  assign qw = REG_WR && (REG_SEL == 2'h3);

  // A quiet cycle after the overflow, so no write can have cleared it.
  sequence rd_sts;
    REG_RD && (REG_SEL == 2'h1) && !REG_WR;
  endsequence
  sequence ovf_rd;
    EVF_OVERFLOW_EVT ##1 !REG_WR ##1 rd_sts;
  endsequence

  step_after_wr_a: assert property (
    qw && REG_WDATA[8] |=> HEAD_STEP_PULSE
  ) else $error("head step pulse missing");
  tail_read_a: assert property (
    REG_RD && (REG_SEL == 2'h2) |=> REG_RDATA == $past(EVF_TAIL_ADDR)
  ) else $error("tail address read wrong");
  status_read_a: assert property (
    rd_sts |=> REG_RDATA[2:0] == {$past(EVF_COUNT) >= EVF_DEPTH,
      $past(EVF_COUNT) >= EVF_DEPTH / 2, $past(EVF_COUNT) != 0}
  ) else $error("status flags wrong");
  ovf_latched_a: assert property (
    ovf_rd |=> REG_RDATA[3]
  ) else $error("overflow flag not held");
  dir_reads_one_a: assert property (
    REG_RD && (REG_SEL == 2'h3) |=> REG_RDATA[7]
  ) else $error("direction bit not one");
  depth_written_a: assert property (
    qw && CONFIG_MODE |=> QUEUE_SLOTS == $past(REG_WDATA[28:24]) + 6'h01
  ) else $error("queue slots wrong");
  cfg_locked_a: assert property (
    qw && !CONFIG_MODE |=> $stable(QUEUE_SLOTS)
  ) else $error("depth changed outside config");
  send_drain_a: assert property (
    QUEUE_DRAINED && !(qw && REG_WDATA[9]) |=> !SEND_ACTIVE
  ) else $error("send request not cleared");
endmodule
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEP = 32;
  // --------
  // Bench signals and expectation tables
  // --------
  logic        clk, rst, wr, rd, cfg, glb;
  logic        ovf, abt, drn, rdn, emp, atd, nfl;
  logic [31:0] tal;
  logic        stp, abp, snd, rsp, irq;
  logic [1:0]  sel;
  logic [31:0] wd, rdat, v;
  logic [5:0]  cnt, qs;
  logic [6:0]  pb;
  logic [4:0]  pri, d5;
  logic [2:0]  rl;
  int          err_total, checked;
  byte         pbt[8] = '{8, 12, 16, 20, 24, 32, 48, 64};
  byte         rlt[4] = '{0, 3, 7, 7};
  byte         cl[6]  = '{0, 1, 15, 16, 31, 32};

  tqr_regs #(.EVF_DEPTH(DEP), .CW(6)) dut (.CORE_CLK(clk), .RST(rst),
    .REG_WR(wr), .REG_RD(rd), .REG_SEL(sel), .REG_WDATA(wd),
    .REG_RDATA(rdat), .CONFIG_MODE(cfg), .RETRY_LIMIT_GLOBAL_EN(glb),
    .EVF_COUNT(cnt), .EVF_TAIL_ADDR(tal), .EVF_OVERFLOW_EVT(ovf),
    .MSG_DONE(1'b0), .MSG_ABORTED(abt), .QUEUE_DRAINED(drn),
    .QUEUE_RESET_DONE(rdn), .ATTEMPTS_DONE(atd), .QUEUE_EMPTY(emp),
    .QUEUE_NOTFULL(nfl), .QUEUE_RESET_PULSE(rsp), .HEAD_STEP_PULSE(stp),
    .ABORT_REQ_PULSE(abp), .SEND_ACTIVE(snd), .PAYLOAD_BYTES(pb),
    .QUEUE_SLOTS(qs), .TX_PRIORITY(pri), .RETRY_LIMIT(rl), .IRQ_REQ(irq));

  // Free-running 50 MHz core clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Compare and count; a mismatch is reported at once.
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Strobes last one cycle; the return waits past the edge so outputs settle.
  task automatic wrr(logic [1:0] s, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    sel <= s;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdd(logic [1:0] s);
    @(posedge clk);
    rd <= 1'b1;
    sel <= s;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdat;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  // Main sequence: configure, leave config mode, then exercise each field.
  initial begin
    {wr, rd, ovf, abt, drn, rdn, emp, atd, nfl} = '0;
    tal = 32'h0000_0A5C;
    {rst, cfg, glb} = 3'h7;
    sel = 2'h0;
    wd = 32'h0000_0000;
    cnt = 6'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdd(2'h3);
    chk("qctl_reset", v, 32'h0060_0480);
    for (int i = 0; i < 8; i++) begin
      d5 = {i[2:0], i[1:0]};
      wrr(2'h3, {i[2:0], d5, 1'b0, i[1:0], d5, 16'h0000});
      chk("bytes", 32'(pb), 32'(pbt[i]));
      chk("slots", 32'(qs), 32'(d5) + 1);
      chk("prio", 32'(pri), 32'(d5));
      chk("retry", 32'(rl), 32'(rlt[i[1:0]]));
    end
    @(posedge clk);
    cfg <= 1'b0;
    glb <= 1'b0;
    #1;
    chk("rst_pulse", rsp, 1);
    chk("retry_off", 32'(rl), 7);
    @(posedge clk);
    rdn <= 1'b1;
    @(posedge clk);
    rdn <= 1'b0;
    rdd(2'h3);
    chk("rst_clear", v & 32'h0000_0400, 0);
    wrr(2'h3, 32'h0000_0000);
    chk("lock", 32'({pb, qs}), 32'({7'h40, 6'h20}));
    wrr(2'h3, 32'h0000_0100);
    chk("step_on", stp, 1);
    @(posedge clk);
    #1;
    chk("step_off", stp, 0);
    wrr(2'h3, 32'h0000_0200);
    chk("send_on", snd, 1);
    wrr(2'h3, 32'h0000_0000);
    chk("abort", abp, 1);
    @(posedge clk);
    abt <= 1'b1;
    @(posedge clk);
    abt <= 1'b0;
    #1;
    chk("send_abt", snd, 0);
    wrr(2'h3, 32'h0000_0200);
    @(posedge clk);
    drn <= 1'b1;
    @(posedge clk);
    drn <= 1'b0;
    #1;
    chk("send_drn", snd, 0);
    // A queue reset requested in normal mode also drops the send request.
    wrr(2'h3, 32'h0000_0600);
    chk("qrst_set", 32'({rsp, snd}), 32'h3);
    @(posedge clk);
    rdn <= 1'b1;
    @(posedge clk);
    rdn <= 1'b0;
    #1;
    chk("send_qrst", 32'({rsp, snd}), 32'h0);
    foreach (cl[k]) begin
      @(posedge clk);
      cnt <= 6'(cl[k]);
      rdd(2'h1);
      chk("status", v, {28'h0, 1'b0, cl[k] >= DEP,
        cl[k] >= DEP / 2, cl[k] != 0});
    end
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    rdd(2'h1);
    chk("ovf_set", v, 32'h0000_000F);
    @(posedge clk);
    cnt <= 6'h00;
    wrr(2'h1, 32'h0000_0007);
    rdd(2'h1);
    chk("ovf_clr", v, 0);
    @(posedge clk);
    tal <= 32'h0001_F3C0;
    rdd(2'h2);
    chk("tail", v, 32'h0001_F3C0);
    @(posedge clk);
    cnt <= 6'h10;
    emp <= 1'b1;
    #1;
    chk("irq_gated", irq, 0);
    wrr(2'h0, 32'h0000_0002);
    chk("irq_half", irq, 1);
    wrr(2'h0, 32'h0000_0001);
    chk("irq_ne", irq, 1);
    // Each source alone, so one broken gate cannot hide behind another.
    wrr(2'h0, 32'h0000_0000);
    chk("irq_evf_off", irq, 0);
    wrr(2'h3, 32'h0000_0004);
    chk("irq_empty", irq, 1);
    @(posedge clk);
    emp <= 1'b0;
    atd <= 1'b1;
    #1;
    chk("irq_att_off", irq, 0);
    wrr(2'h3, 32'h0000_0010);
    chk("irq_att", irq, 1);
    @(posedge clk);
    atd <= 1'b0;
    nfl <= 1'b1;
    #1;
    chk("irq_nf_off", irq, 0);
    wrr(2'h3, 32'h0000_0001);
    chk("irq_nf", irq, 1);
    @(posedge clk);
    nfl <= 1'b0;
    cnt <= 6'h20;
    #1;
    chk("irq_full_off", irq, 0);
    wrr(2'h0, 32'h0000_0004);
    chk("irq_full", irq, 1);
    @(posedge clk);
    cnt <= 6'h00;
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    #1;
    chk("irq_ovf_off", irq, 0);
    wrr(2'h0, 32'h0000_0008);
    chk("irq_ovf", irq, 1);
    complete_run();
  end
endmodule

// The checker watches the register bank's own ports.
bind tqr_regs tqr_regs_props #(.EVF_DEPTH(EVF_DEPTH), .CW(CW)) u_props (
  .CORE_CLK, .RST, .REG_WR, .REG_RD, .REG_SEL, .REG_WDATA, .REG_RDATA,
  .CONFIG_MODE, .EVF_COUNT, .EVF_TAIL_ADDR, .EVF_OVERFLOW_EVT,
  .QUEUE_DRAINED, .HEAD_STEP_PULSE, .SEND_ACTIVE, .QUEUE_SLOTS);
`default_nettype wire
